//--- logic/srs_pkg.sv
// Shared constants and types of the serial register streaming port.
package srs_pkg;

  // ------------------------------------------------------------------------
  // Address space
  // ------------------------------------------------------------------------
  localparam int ADDR_W    = 7;
  localparam int PAGE_W    = 3;
  localparam int LRA_W     = 4;
  localparam int REG_COUNT = 128;

  localparam logic [6:0] ADDR_STREAM_CTRL = 7'h03;
  localparam logic [6:0] ADDR_RES_HIGH    = 7'h1A;
  localparam logic [6:0] ADDR_RES_MID     = 7'h1B;
  localparam logic [6:0] ADDR_RES_LOW     = 7'h1C;

  // ------------------------------------------------------------------------
  // Stream control fields and reset value
  // ------------------------------------------------------------------------
  localparam int         STREAM_KIND_BIT = 7;
  localparam int         SPAN_LSB        = 0;
  localparam int         SPAN_W          = 3;
  localparam logic [7:0] STREAM_CTRL_RST = 8'h00;

  // ------------------------------------------------------------------------
  // Instruction bytes
  // ------------------------------------------------------------------------
  localparam logic [7:0] INST_PAGE_WR  = 8'h10;
  localparam logic [7:0] INST_PAGE_RD  = 8'h90;
  localparam int         INST_RW_BIT   = 7;
  localparam int         INST_SIZE_LSB = 5;
  localparam int         INST_SEL_BIT  = 4;
  localparam logic [1:0] SIZE_STREAM   = 2'h3;

  // ------------------------------------------------------------------------
  // Conversion result
  // ------------------------------------------------------------------------
  localparam int          RES_W   = 24;
  localparam logic [23:0] SAT_POS = 24'h7F_FFFF;
  localparam logic [23:0] SAT_NEG = 24'h80_0000;

  typedef enum logic [3:0] {
    ST_INST = 4'h1,
    ST_PAGE = 4'h2,
    ST_DATA = 4'h4,
    ST_SKIP = 4'h8
  } srs_state_t;

endpackage

//--- logic/srs_byte_if.sv
// Byte-level link between the serial shifter and the register engine.
`timescale 1ns/1ps
`default_nettype none
interface srs_byte_if;
  logic       active;
  logic       rx_valid;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;
  logic       tx_bit;

  modport shifter (output active, output rx_valid, output rx_byte,
                   output tx_bit, input tx_byte);
  modport ctrl    (input active, input rx_valid, input rx_byte,
                   input tx_bit, output tx_byte);
endinterface
`default_nettype wire

//--- logic/srs_shifter.sv
// Serial shifter: pin synchronisers, clock edge detection, byte framing.
`timescale 1ns/1ps
`default_nettype none
module srs_shifter (
  input  wire logic   ref_clk,
  input  wire logic   reset,
  input  wire logic   sclk,
  input  wire logic   select_n,
  input  wire logic   sdi,
  srs_byte_if.shifter bus
);

  typedef struct packed {
    logic [1:0] sclk_s;
    logic [1:0] sel_s;
    logic [1:0] sdi_s;
    logic       sclk_p;
    logic       act;
    logic [2:0] bitcnt;
    logic [7:0] rx;
    logic [7:0] tx;
    logic       rxv;
  } srs_shift_t;

  srs_shift_t q;
  srs_shift_t d;

  // ------------------------------------------------------------------------
  // Framing and shifting
  // ------------------------------------------------------------------------
  always_comb begin
    d        = q;
    d.sclk_s = {q.sclk_s[0], sclk};
    d.sel_s  = {q.sel_s[0], select_n};
    d.sdi_s  = {q.sdi_s[0], sdi};
    d.sclk_p = q.sclk_s[1];
    d.act    = ~q.sel_s[1];
    d.rxv    = 1'b0;
    if (!q.act) begin
      // Byte alignment restarts each time select falls.
      d.bitcnt = 3'h0;
      d.tx     = bus.tx_byte;
    end else if (q.sclk_s[1] && !q.sclk_p) begin
      d.rx     = {q.rx[6:0], q.sdi_s[1]};
      d.bitcnt = 3'(q.bitcnt + 3'h1);
      d.rxv    = (q.bitcnt == 3'h7);
    end else if (!q.sclk_s[1] && q.sclk_p) begin
      // Most significant bit first; a new byte loads at its boundary.
      d.tx = (q.bitcnt == 3'h0) ? bus.tx_byte : {q.tx[6:0], 1'b0};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q <= '0;
      q.sclk_s <= 2'h0;
      q.sel_s  <= 2'h3;
    end else begin
      q <= d;
    end
  end

  assign bus.active   = q.act;
  assign bus.rx_valid = q.rxv;
  assign bus.rx_byte  = q.rx;
  assign bus.tx_bit   = q.tx[7];

endmodule // srs_shifter
`default_nettype wire

//--- logic/srs_regport.sv
// Register engine of the serial register port with streaming access.
// Function
// - Conversion result is held as a 24-bit two's complement value.
// - Out-of-range results clamp to the largest positive or negative code.
// - Page setup instruction is 0x10 for write and 0x90 for read.
// - Multi-byte access walks incrementing addresses; a fixed size ends after size code + 1 bytes.
// - Normal streaming is selected after reset.
// - Size code 0x3 keeps transferring bytes until select is released.
// - Stream kind bit high in register 0x03 selects controlled streaming.
// - Stream span holds the window register count minus one.
// - Controlled streaming wraps from the window end back to its start.
// - Controlled streaming lasts until select is released.
// - Result bytes sit at 0x1A high, 0x1B middle, 0x1C low.
`timescale 1ns/1ps
`default_nettype none
module srs_regport #(
  parameter int RAW_W = 28
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             sclk,
  input  wire logic             select_n,
  input  wire logic             sdi,
  input  wire logic [RAW_W-1:0] conv_code,
  input  wire logic             conv_strobe,
  output var  logic             sdo,
  output var  logic             sdo_oe
);

  typedef struct packed {
    srs_pkg::srs_state_t                       st;
    logic                                      rd;
    logic                                      strm;
    logic [1:0]                                left;
    logic [srs_pkg::SPAN_W-1:0]                pos;
    logic [srs_pkg::ADDR_W-1:0]                start;
    logic [srs_pkg::ADDR_W-1:0]                addr;
    logic [srs_pkg::PAGE_W-1:0]                page;
    logic [srs_pkg::RES_W-1:0]                 result;
    logic [srs_pkg::REG_COUNT-1:0][7:0]        mem;
    logic                                      sdo;
    logic                                      sdo_oe;
  } srs_main_t;

  localparam srs_main_t MAIN_RST = '{st: srs_pkg::ST_INST, default: '0};

  srs_main_t  q;
  srs_main_t  d;
  srs_byte_if bus ();

  srs_shifter u_shifter (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .sclk     (sclk),
    .select_n (select_n),
    .sdi      (sdi),
    .bus      (bus)
  );

  // ------------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------------
  function automatic logic is_result(input logic [6:0] a);
    is_result = (a == srs_pkg::ADDR_RES_HIGH) ||
                (a == srs_pkg::ADDR_RES_MID) ||
                (a == srs_pkg::ADDR_RES_LOW);
  endfunction

  function automatic logic [7:0] rd_byte(input srs_main_t s,
                                         input logic [6:0] a);
    if (a == srs_pkg::ADDR_RES_HIGH) begin
      rd_byte = s.result[23:16];
    end else if (a == srs_pkg::ADDR_RES_MID) begin
      rd_byte = s.result[15:8];
    end else if (a == srs_pkg::ADDR_RES_LOW) begin
      rd_byte = s.result[7:0];
    end else begin
      rd_byte = s.mem[a];
    end
  endfunction

  function automatic logic [23:0] saturate(input logic [RAW_W-1:0] x);
    if ((&x[RAW_W-1:23]) || !(|x[RAW_W-1:23])) begin
      saturate = x[23:0];
    end else begin
      saturate = x[RAW_W-1] ? srs_pkg::SAT_NEG : srs_pkg::SAT_POS;
    end
  endfunction

  // ------------------------------------------------------------------------
  // Transaction engine
  // ------------------------------------------------------------------------
  logic       kind_ctl;
  logic [2:0] span;

  assign kind_ctl = q.mem[srs_pkg::ADDR_STREAM_CTRL][srs_pkg::STREAM_KIND_BIT];
  assign span     = q.mem[srs_pkg::ADDR_STREAM_CTRL][srs_pkg::SPAN_LSB +:
                                                     srs_pkg::SPAN_W];

  always_comb begin
    d        = q;
    d.sdo    = bus.tx_bit;
    d.sdo_oe = bus.active && q.rd &&
               (q.st == srs_pkg::ST_DATA || q.st == srs_pkg::ST_PAGE);
    if (conv_strobe) begin
      d.result = saturate(conv_code);
    end
    if (!bus.active) begin
      d.st = srs_pkg::ST_INST;
      d.rd = 1'b0;
    end else if (bus.rx_valid) begin
      case (q.st)
        srs_pkg::ST_INST: begin
          if (bus.rx_byte == srs_pkg::INST_PAGE_WR) begin
            d.st = srs_pkg::ST_PAGE;
            d.rd = 1'b0;
          end else if (bus.rx_byte == srs_pkg::INST_PAGE_RD) begin
            d.st = srs_pkg::ST_PAGE;
            d.rd = 1'b1;
          end else if (bus.rx_byte[srs_pkg::INST_SEL_BIT]) begin
            d.st = srs_pkg::ST_SKIP;
          end else begin
            // Data access reuses the stored page without a setup.
            d.st    = srs_pkg::ST_DATA;
            d.rd    = bus.rx_byte[srs_pkg::INST_RW_BIT];
            d.left  = bus.rx_byte[srs_pkg::INST_SIZE_LSB +: 2];
            d.strm  = (bus.rx_byte[srs_pkg::INST_SIZE_LSB +: 2] ==
                       srs_pkg::SIZE_STREAM);
            d.addr  = {q.page, bus.rx_byte[srs_pkg::LRA_W-1:0]};
            d.start = {q.page, bus.rx_byte[srs_pkg::LRA_W-1:0]};
            d.pos   = '0;
          end
        end
        srs_pkg::ST_PAGE: begin
          if (!q.rd) begin
            d.page = bus.rx_byte[srs_pkg::PAGE_W-1:0];
          end
          d.st = srs_pkg::ST_SKIP;
        end
        srs_pkg::ST_DATA: begin
          if (!q.rd && !is_result(q.addr)) begin
            d.mem[q.addr] = bus.rx_byte;
          end
          if (q.strm && kind_ctl && q.pos == span) begin
            d.addr = q.start;
            d.pos  = '0;
          end else begin
            d.addr = 7'(q.addr + 7'h01);
            d.pos  = 3'(q.pos + 3'h1);
          end
          if (!q.strm) begin
            if (q.left == 2'h0) begin
              d.st = srs_pkg::ST_SKIP;
            end else begin
              d.left = 2'(q.left - 2'h1);
            end
          end
        end
        default: begin
          d.st = srs_pkg::ST_SKIP;
        end
      endcase
    end
  end

  always_comb begin
    if (q.st == srs_pkg::ST_DATA && q.rd) begin
      bus.tx_byte = rd_byte(q, q.addr);
    end else if (q.st == srs_pkg::ST_PAGE && q.rd) begin
      bus.tx_byte = {5'h00, q.page};
    end else begin
      bus.tx_byte = 8'h00;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q <= MAIN_RST;
      q.mem[srs_pkg::ADDR_STREAM_CTRL] <= srs_pkg::STREAM_CTRL_RST;
    end else begin
      q <= d;
    end
  end

  assign sdo    = q.sdo;
  assign sdo_oe = q.sdo_oe;

endmodule // srs_regport
`default_nettype wire

//--- bench/srs_regport_assertions.sv
// Port-level checks of the serial register streaming port.
`timescale 1ns/1ps
`default_nettype none
module srs_regport_assertions #(
  parameter int RAW_W = 28
) (
  input wire logic             ref_clk,
  input wire logic             reset,
  input wire logic             sclk,
  input wire logic             select_n,
  input wire logic             sdi,
  input wire logic [RAW_W-1:0] conv_code,
  input wire logic             conv_strobe,
  input wire logic             sdo,
  input wire logic             sdo_oe
);
  logic [3:0] hi_cnt_q;
  logic [6:0] edge_cnt_q;
  logic       sclk_q;
  // Counts cycles of released select and sclk rises inside a frame.
  always_ff @(posedge ref_clk) begin
    sclk_q <= sclk;
    if (reset || !select_n) hi_cnt_q <= 4'h0;
    else if (hi_cnt_q != 4'hF) hi_cnt_q <= hi_cnt_q + 4'h1;
    if (reset || select_n) edge_cnt_q <= 7'h00;
    else if (sclk && !sclk_q && edge_cnt_q != 7'h7F)
      edge_cnt_q <= edge_cnt_q + 7'h01;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  AST_RESET_QUIET: assert property ($fell(reset) |-> !sdo_oe && !sdo)
    else $error("sdo active right after reset");
  AST_OE_IDLE: assert property (hi_cnt_q >= 4'h8 |-> !sdo_oe)
    else $error("sdo_oe high with select released");
  AST_SDO_IDLE: assert property (hi_cnt_q >= 4'h8 |-> sdo == 1'b0)
    else $error("sdo not low with select released");
  AST_SDO_STABLE: assert property (sclk [*6] |-> $stable(sdo))
    else $error("sdo changed while sclk high");
  AST_OE_AT_BYTE8: assert property (
    $rose(sdo_oe) |-> edge_cnt_q == 7'h08)
    else $error("sdo_oe rose off the instruction boundary");
  // A fixed-size read lets go of sdo only after a whole byte.
  AST_OE_HOLD: assert property (
    sdo_oe && !select_n && edge_cnt_q[2:0] != 3'h0 |=> sdo_oe)
    else $error("sdo_oe dropped inside a byte");
  AST_OE_FELL_REL: assert property (
    $fell(sdo_oe) |-> hi_cnt_q >= 4'h2 ||
      (edge_cnt_q[2:0] == 3'h0 && edge_cnt_q >= 7'h10))
    else $error("sdo_oe fell off a byte boundary");
  AST_OE_DROP_BOUND: assert property (
    $rose(select_n) && sdo_oe |-> ##[1:8] !sdo_oe)
    else $error("sdo_oe stayed high after release");
  cover property ($rose(sdo_oe));
  cover property (conv_strobe);
  cover property (sdo_oe && edge_cnt_q == 7'h1F);
  cover property (!select_n && sdi);
  cover property (conv_strobe && conv_code[RAW_W-1]);
endmodule  // srs_regport_assertions
`default_nettype wire

//--- bench/srs_host_model.sv
// Host-side serial master model, mode 0, clock still between frames.
`timescale 1ns/1ps
`default_nettype none
module srs_host_model (
  input  wire logic ref_clk,
  output var  logic sclk,
  output var  logic select_n,
  output var  logic sdi,
  input  wire logic sdo
);
  logic [7:0] tx [16];
  logic [7:0] rx [16];
  initial begin
    sclk = 1'b0;
    select_n = 1'b1;
    sdi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Sends n bytes msb first and keeps what came back on sdo.
  task automatic frame(input int n);
    tick(1);
    select_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      for (int b = 7; b >= 0; b--) begin
        sdi = tx[i][b];
        tick(8);
        sclk = 1'b1;
        rx[i][b] = sdo;
        tick(8);
        sclk = 1'b0;
      end
    end
    tick(8);
    select_n = 1'b1;
    sdi = ~sdi;
    tick(8);
  endtask
endmodule  // srs_host_model
`default_nettype wire

//--- bench/srs_regport_test.sv
// Self-checking bench of the serial register streaming port.
`timescale 1ns/1ps
`default_nettype none
module srs_regport_test;
  localparam int RAW_W = 28;
  logic ref_clk, reset, sclk, select_n, sdi, conv_strobe, sdo, sdo_oe;
  logic [RAW_W-1:0] conv_code;
  logic [15:0] lfsr_q;
  int err_count, compares, page, res;
  int mem [128];
  int vals [8] = '{5, -5, 134217727, -134217728, 8388607, -8388608,
                   8388608, -8388609};
  srs_host_model host (.ref_clk(ref_clk), .sclk(sclk),
    .select_n(select_n), .sdi(sdi), .sdo(sdo));
  srs_regport #(.RAW_W(RAW_W)) dut (.ref_clk(ref_clk), .reset(reset),
    .sclk(sclk), .select_n(select_n), .sdi(sdi), .conv_code(conv_code),
    .conv_strobe(conv_strobe), .sdo(sdo), .sdo_oe(sdo_oe));
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic int rd_exp(input int a);
    if (a >= 26 && a <= 28) return (res >> (8 * (28 - a))) & 255;
    return mem[a];
  endfunction
  task automatic check8(input string nm, input logic [7:0] e,
                        input logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // One data access frame; the model walks the same addresses.
  task automatic access(input logic [7:0] inst, input int n);
    int a;
    a = page * 16 + inst[3:0];
    host.tx[0] = inst;
    for (int k = 1; k <= n; k++) begin
      lfsr_q = lfsr_next(lfsr_q);
      host.tx[k] = lfsr_q[7:0];
    end
    host.frame(n + 1);
    for (int k = 1; k <= n; k++) begin
      if (inst[7]) check8("rd", 8'(rd_exp(a)), host.rx[k]);
      else if (a < 26 || a > 28) mem[a] = host.tx[k];
      a = (a + 1) % 128;
      if (inst[6:5] == 2'h3 && mem[3] >= 128 && k % (mem[3] % 8 + 1) == 0)
        a = page * 16 + inst[3:0];
    end
  endtask
  task automatic set_page(input int p);
    host.tx[0] = srs_pkg::INST_PAGE_WR;
    host.tx[1] = 8'(p);
    host.frame(2);
    page = p;
    host.tx[0] = srs_pkg::INST_PAGE_RD;
    host.frame(2);
    check8("page", 8'(p), host.rx[1]);
  endtask
  task automatic convert(input int v);
    conv_code = RAW_W'(v);
    conv_strobe = 1'b1;
    host.tick(1);
    conv_strobe = 1'b0;
    res = v > 8388607 ? 8388607 : (v < -8388608 ? -8388608 : v);
    res = res & 32'h00FF_FFFF;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end
  initial begin
    reset = 1'b1;
    conv_code = '0;
    conv_strobe = 1'b0;
    lfsr_q = 16'h0050;
    foreach (mem[i]) mem[i] = 0;
    repeat (6) @(posedge ref_clk);
    #1 reset = 1'b0;
    host.tick(6);
    access(8'h83, 1);
    access(8'h45, 3);
    access(8'hC5, 3);
    access(8'h68, 6);
    access(8'hE8, 6);
    $display("test access done");
    set_page(1);
    for (int i = 0; i < 10; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      convert(i < 8 ? vals[i] : int'($signed({lfsr_q, lfsr_q[11:0]})));
      host.tick(4);
      access(8'hCA, 3);
    end
    access(8'h4A, 3);
    access(8'hCA, 3);
    host.tx[0] = 8'h93;
    host.tx[1] = 8'hFF;
    host.frame(2);
    check8("refused", 8'h00, host.rx[1]);
    $display("test result done");
    set_page(0);
    host.tx[0] = 8'(srs_pkg::ADDR_STREAM_CTRL);
    host.tx[1] = 8'h82;
    host.frame(2);
    mem[3] = 130;
    access(8'h83, 1);
    set_page(1);
    access(8'hEA, 10);
    access(8'hEA, 4);
    $display("test stream done");
    report_and_stop();
  end
endmodule  // srs_regport_test
bind srs_regport srs_regport_assertions #(.RAW_W(RAW_W)) u_chk (
  .ref_clk(ref_clk), .reset(reset), .sclk(sclk), .select_n(select_n),
  .sdi(sdi), .conv_code(conv_code), .conv_strobe(conv_strobe),
  .sdo(sdo), .sdo_oe(sdo_oe));
`default_nettype wire
